// ==== tpcsr_defs.vh ====
// Constants for the ternary receive coding layer.
// Assumes a 125 MHz clock; included by bare name.
`ifndef TPCSR_DEFS_VH
`define TPCSR_DEFS_VH
// Symbol encoding: 2'b01 = +1, 2'b11 = -1, 2'b00 = 0
`define TPCSR_SYM_POS 2'b01
`define TPCSR_SYM_NEG 2'b11
`define TPCSR_SYM_ZERO 2'b00
`define TPCSR_BAL_INIT 3'h2
`define TPCSR_BAL_MIN 3'h1
`define TPCSR_BAL_MAX 3'h4
`define TPCSR_BAL_AFTER_RESET 3'h1
// Triples as {A,B,C}, 2 bits each
`define TPCSR_ALIGN_MARKER 6'h00
`define TPCSR_START_TAIL 6'h17
`define TPCSR_END_TAIL 6'h1D
`define TPCSR_END_ERR_TAIL 6'h35
`define TPCSR_BRST_B1 6'h31
`define TPCSR_BRST_B2 6'h30
`define TPCSR_BRST_B3 6'h33
`define TPCSR_BRST_B4 6'h3F
// Delay line depth between delimiter and data
`define TPCSR_FLUSH_DEPTH 5
// Frame-length guard, in microseconds and clock cycles
`define TPCSR_GUARD_US 2000
`define TPCSR_CLK_MHZ 125
`define TPCSR_GUARD_CYCLES (`TPCSR_GUARD_US * `TPCSR_CLK_MHZ)
// Polarity lock window in cycles
`define TPCSR_POL_WINDOW 65536
`define TPCSR_IDLE_LOCK_COUNT 6'h20
`define TPCSR_IDLE_MISS_MAX 4'h8
`endif

// ==== tpcsr_receive.v ====
// Receive side of a single-pair ternary coding layer: symbol alignment,
// triple decoding with running balance, descrambling and MII receive output.
// Assumes one ternary symbol per symValid pulse from the medium attachment.
`timescale 1ns/100ps
`include "tpcsr_defs.vh"
`default_nettype none

module tpcsr_receive (
	input wire clk,
	input wire rstn,
	input wire mgmtReset,
	input wire symValid,
	input wire [1:0] symIn,
	input wire localReceiverHealth,
	input wire isMaster,
	input wire loopbackEn,
	input wire [3:0] txd,
	input wire txEn,
	input wire txEr,
	output reg [3:0] rxd,
	output reg rxDv,
	output reg rxEr,
	output wire receiving,
	output wire descramblerLock,
	output wire balanceViolation,
	output wire overlongFrameFlag,
	output wire farReceiverHealth,
	output wire farLowPowerRequest,
	output wire rxPolarityFlipped,
	output wire txMediumMute,
	output wire codingLayerReset
);

	// ------------------------------------------------------------
	// Reset and input synchronisation
	// ------------------------------------------------------------
	reg healthS1_r, healthS2_r, mgmtS1_r, mgmtS2_r, lbS1_r, lbS2_r, porDone_r;
	always @(posedge clk) begin
		healthS1_r <= localReceiverHealth;
		healthS2_r <= healthS1_r;
		mgmtS1_r <= mgmtReset;
		mgmtS2_r <= mgmtS1_r;
		lbS1_r <= loopbackEn;
		lbS2_r <= lbS1_r;
		porDone_r <= rstn;
	end
	// Power-on (rstn) and management reset both hold the layer in reset
	wire layerRst = !rstn || !porDone_r || mgmtS2_r;
	assign codingLayerReset = layerRst;
	wire health = healthS2_r;
	wire loopback = lbS2_r;
	assign txMediumMute = loopback;

	// ------------------------------------------------------------
	// Table functions
	// ------------------------------------------------------------
	// Encode nibble at balance b: returns {change[2:0] signed, triple[5:0]}
	function [8:0] enc;
		input [3:0] n;
		input [2:0] b;
		reg hi;
		begin
			hi = (b != 3'h1);
			enc = 9'h000;
			case (n)
				4'h0: enc = hi ? {3'h7, 6'h0C} : {3'h2, 6'h11};
				4'h1: enc = {3'h0, 6'h0D};
				4'h2: enc = {3'h0, 6'h1C};
				4'h3: enc = (b == 3'h4) ? {3'h6, 6'h0F} : {3'h1, 6'h01};
				4'h4: enc = {3'h0, 6'h34};
				4'h5: enc = hi ? {3'h7, 6'h30} : {3'h2, 6'h05};
				4'h6: enc = (b >= 3'h3) ? {3'h7, 6'h1F} : {3'h1, 6'h35};
				4'h7: enc = {3'h0, 6'h31};
				4'h8: enc = (b == 3'h4) ? {3'h6, 6'h3C} : {3'h1, 6'h10};
				4'h9: enc = (b == 3'h4) ? {3'h5, 6'h3F} : {3'h1, 6'h1D};
				4'hA: enc = (b >= 3'h3) ? {3'h7, 6'h3D} : {3'h1, 6'h17};
				4'hB: enc = {3'h0, 6'h13};
				4'hC: enc = hi ? {3'h7, 6'h37} : {3'h3, 6'h15};
				4'hD: enc = (b == 3'h4) ? {3'h6, 6'h33} : {3'h1, 6'h04};
				4'hE: enc = {3'h0, 6'h07};
				4'hF: enc = hi ? {3'h7, 6'h03} : {3'h2, 6'h14};
				default: enc = 9'h000;
			endcase
		end
	endfunction

	// Inverse: searches all nibbles at the current balance
	function [4:0] dec;
		input [5:0] t;
		input [2:0] b;
		integer i;
		reg [8:0] e;
		begin
			dec = 5'h00;
			for (i = 15; i >= 0; i = i - 1) begin
				e = enc(i[3:0], b);
				if (e[5:0] == t)
					dec = {1'b1, i[3:0]};
			end
		end
	endfunction

	function isBalReset;
		input [5:0] t;
		begin
			isBalReset = (t == `TPCSR_BRST_B1) || (t == `TPCSR_BRST_B2) ||
				(t == `TPCSR_BRST_B3) || (t == `TPCSR_BRST_B4);
		end
	endfunction

	// ------------------------------------------------------------
	// Polarity correction and triple alignment
	// ------------------------------------------------------------
	reg polFlip_r, tripleReady_r, lock_r;
	// Negating a 2-bit code: swap +1 and -1, zero stays
	wire [1:0] symPol = polFlip_r ? (~symIn + 2'h1) : symIn;
	reg [5:0] shift_r, triple_r;
	reg [1:0] phase_r;
	wire inIdle;
	always @(posedge clk) begin
		if (layerRst) begin
			shift_r <= 6'h00;
			phase_r <= 2'h0;
			tripleReady_r <= 1'b0;
			triple_r <= 6'h00;
		end else begin
			tripleReady_r <= 1'b0;
			if (symValid && !loopback) begin
				shift_r <= {shift_r[3:0], symPol};
				if (phase_r == 2'h2) begin
					phase_r <= 2'h0;
					tripleReady_r <= 1'b1;
					triple_r <= {shift_r[3:0], symPol};
				end else begin
					phase_r <= phase_r + 2'h1;
				end
			end
			// Marker never occurs when aligned: slip one symbol
			if (tripleReady_r && inIdle && triple_r == `TPCSR_ALIGN_MARKER)
				phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Decode, running balance
	// ------------------------------------------------------------
	reg [2:0] bal_r;
	wire [4:0] decRes = dec(triple_r, bal_r);
	wire [8:0] reenc = enc(decRes[3:0], bal_r);
	wire isBr = isBalReset(triple_r);
	wire isTail = (triple_r == `TPCSR_START_TAIL) || (triple_r == `TPCSR_END_TAIL) ||
		(triple_r == `TPCSR_END_ERR_TAIL);
	wire legal = decRes[4] && (reenc[5:0] == triple_r);
	wire viol = tripleReady_r && !legal && !isBr && !isTail &&
		(triple_r != `TPCSR_ALIGN_MARKER);
	assign balanceViolation = viol;
	reg [2:0] balNxt;
	always @* begin
		balNxt = bal_r;
		if (isBr)
			balNxt = `TPCSR_BAL_AFTER_RESET;
		else if (isTail)
			balNxt = bal_r + 3'h1;
		else if (legal)
			balNxt = bal_r + reenc[8:6];
		if (balNxt < `TPCSR_BAL_MIN || balNxt > `TPCSR_BAL_MAX)
			balNxt = `TPCSR_BAL_INIT;
	end
	always @(posedge clk) begin
		if (layerRst)
			bal_r <= `TPCSR_BAL_INIT;
		else if (tripleReady_r)
			bal_r <= balNxt;
	end

	// ------------------------------------------------------------
	// Side-stream descrambler and idle lock
	// ------------------------------------------------------------
	reg [32:0] scr_r;
	wire tapMid = isMaster ? scr_r[19] : scr_r[12];
	wire scrBit = scr_r[32] ^ tapMid;
	wire [3:0] scrWord = {scr_r[2], scr_r[1], scr_r[0], scrBit};
	// Idle swaps bits 1 and 2 of the scrambler word
	wire [1:0] expIdle = {scrWord[2], scrWord[0]};
	wire idleMatch = (decRes[1:0] == expIdle);
	reg [5:0] goodCnt_r;
	reg [3:0] missCnt_r, farBits_r;
	always @(posedge clk) begin
		if (layerRst) begin
			scr_r <= 33'h0_0000_0001;
			goodCnt_r <= 6'h00;
			missCnt_r <= 4'h0;
			lock_r <= 1'b0;
			farBits_r <= 4'h0;
		end else if (tripleReady_r) begin
			scr_r <= {scr_r[31:0], scrBit};
			if (inIdle && legal) begin
				farBits_r <= decRes[3:0];
				if (idleMatch) begin
					missCnt_r <= 4'h0;
					if (goodCnt_r == `TPCSR_IDLE_LOCK_COUNT)
						lock_r <= 1'b1;
					else
						goodCnt_r <= goodCnt_r + 6'h01;
				end else begin
					// Reseed from received bits to acquire state
					scr_r <= {scr_r[31:0], decRes[0]};
					goodCnt_r <= 6'h00;
					if (missCnt_r == `TPCSR_IDLE_MISS_MAX)
						lock_r <= 1'b0;
					else
						missCnt_r <= missCnt_r + 4'h1;
				end
			end
		end
	end
	assign descramblerLock = lock_r;
	assign farReceiverHealth = farBits_r[3];
	assign farLowPowerRequest = farBits_r[2];

	// ------------------------------------------------------------
	// Polarity search
	// ------------------------------------------------------------
	reg [16:0] polCnt_r;
	always @(posedge clk) begin
		if (layerRst) begin
			polFlip_r <= 1'b0;
			polCnt_r <= 17'h0_0000;
		end else if (lock_r) begin
			polCnt_r <= 17'h0_0000;
		end else if (polCnt_r == `TPCSR_POL_WINDOW) begin
			polFlip_r <= !polFlip_r;
			polCnt_r <= 17'h0_0000;
		end else begin
			polCnt_r <= polCnt_r + 17'h0_0001;
		end
	end
	assign rxPolarityFlipped = polFlip_r;

	// ------------------------------------------------------------
	// Receive state machine and guard timer
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_TAIL = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_HOLD = 2'h3;
	reg [1:0] st_r;
	reg [17:0] guard_r;
	reg [`TPCSR_FLUSH_DEPTH*5-1:0] dly_r;
	reg [4:0] fillCnt_r;
	reg overlong_r, errTail_r;
	assign inIdle = (st_r == ST_IDLE);
	wire [4:0] dlyOut = dly_r[`TPCSR_FLUSH_DEPTH*5-1 -: 5];
	always @(posedge clk) begin
		if (layerRst) begin
			st_r <= ST_IDLE;
			guard_r <= 18'h0_0000;
			dly_r <= {`TPCSR_FLUSH_DEPTH*5{1'b0}};
			fillCnt_r <= 5'h00;
			overlong_r <= 1'b0;
			errTail_r <= 1'b0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					guard_r <= 18'h0_0000;
					errTail_r <= 1'b0;
					if (tripleReady_r && health && isBr)
						st_r <= ST_TAIL;
				end
				ST_TAIL: begin
					if (tripleReady_r) begin
						if (triple_r == `TPCSR_START_TAIL) begin
							st_r <= ST_DATA;
							fillCnt_r <= 5'h00;
						end else begin
							st_r <= ST_IDLE;
							errTail_r <= !isTail;
						end
					end
				end
				ST_DATA: begin
					guard_r <= guard_r + 18'h0_0001;
					if (guard_r == `TPCSR_GUARD_CYCLES - 1) begin
						st_r <= ST_HOLD;
						overlong_r <= 1'b1;
					end else if (tripleReady_r) begin
						dly_r <= {dly_r[`TPCSR_FLUSH_DEPTH*5-6:0], viol, decRes[3:0] ^ scrWord};
						if (fillCnt_r != `TPCSR_FLUSH_DEPTH)
							fillCnt_r <= fillCnt_r + 5'h01;
						if (isBr)
							st_r <= ST_TAIL;
					end
				end
				ST_HOLD: begin
					if (!health || tripleReady_r && triple_r == `TPCSR_ALIGN_MARKER) begin
						st_r <= ST_IDLE;
						overlong_r <= 1'b0;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end
	assign overlongFrameFlag = overlong_r;
	assign receiving = (st_r == ST_DATA);

	// ------------------------------------------------------------
	// MII receive output
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (layerRst) begin
			rxd <= 4'h0;
			rxDv <= 1'b0;
			rxEr <= 1'b0;
		end else if (loopback) begin
			rxd <= txd;
			rxDv <= txEn;
			rxEr <= txEr;
		end else begin
			if (st_r == ST_DATA && fillCnt_r == `TPCSR_FLUSH_DEPTH) begin
				rxd <= dlyOut[3:0];
				rxDv <= 1'b1;
				rxEr <= dlyOut[4];
			end else if (st_r == ST_TAIL && tripleReady_r && isTail &&
					triple_r != `TPCSR_START_TAIL) begin
				rxDv <= 1'b0;
				rxEr <= (triple_r == `TPCSR_END_ERR_TAIL);
			end else if (st_r == ST_TAIL && tripleReady_r && !isTail) begin
				rxDv <= 1'b0;
				rxEr <= 1'b1;
			end else if (inIdle && !errTail_r) begin
				rxDv <= 1'b0;
				rxEr <= 1'b0;
			end else if (st_r == ST_HOLD) begin
				rxDv <= 1'b0;
			end
		end
	end

endmodule // tpcsr_receive
`default_nettype wire

// ==== tpcsr_rx_monitor.sv ====
// Port checker for the ternary receive coding layer.
// Assumes it is bound into tpcsr_receive and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module tpcsr_rx_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic mgmtReset,
	input wire logic symValid,
	input wire logic loopbackEn,
	input wire logic [3:0] txd,
	input wire logic txEn,
	input wire logic txEr,
	input wire logic [3:0] rxd,
	input wire logic rxDv,
	input wire logic rxEr,
	input wire logic receiving,
	input wire logic descramblerLock,
	input wire logic balanceViolation,
	input wire logic overlongFrameFlag,
	input wire logic rxPolarityFlipped,
	input wire logic txMediumMute,
	input wire logic codingLayerReset
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!rstn);

AST_RESET_QUIET: assert property (codingLayerReset && $past(codingLayerReset) |->
	rxDv == 1'h0 && rxEr == 1'h0 && rxd == 4'h0) else $error("outputs active in reset");
AST_RESET_STATUS: assert property (codingLayerReset && $past(codingLayerReset) |->
	!descramblerLock && !overlongFrameFlag && !rxPolarityFlipped && !receiving)
	else $error("status active in reset");
AST_MGMT_RESET: assert property (mgmtReset [*4] |-> codingLayerReset)
	else $error("management reset not applied");
AST_OVERLONG_IDLE: assert property (overlongFrameFlag |-> !receiving)
	else $error("overlong hold while receiving");
AST_LOOP_DATA: assert property (txMediumMute && $past(txMediumMute) && !codingLayerReset
	&& !$past(codingLayerReset) |-> rxd == $past(txd) && rxDv == $past(txEn)
	&& rxEr == $past(txEr)) else $error("loopback data mismatch");
AST_LOOP_ENTRY: assert property ($rose(loopbackEn) && !codingLayerReset |->
	##[1:4] (txMediumMute || codingLayerReset)) else $error("loopback not entered");
AST_VIOL_CAUSE: assert property (balanceViolation |-> $past(symValid))
	else $error("violation without triple");
AST_VIOL_PULSE: assert property (balanceViolation |=> !balanceViolation)
	else $error("violation longer than one cycle");
endmodule // tpcsr_rx_monitor
`default_nettype wire

// ==== tpcsr_sym_src.sv ====
// Medium-attachment symbol source for the ternary receive bench.
// Assumes symbols are taken on the rising edge; drives on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module tpcsr_sym_src (
	input wire logic clk,
	output logic symValid,
	output logic [1:0] symIn
);
initial begin
	symValid = 1'h0;
	symIn = 2'h2;
end
// Idle line shows the inverted last symbol, never a stale valid one
task send_triple(input logic [5:0] t);
	for (int i = 2; i >= 0; i--) begin
		@(negedge clk);
		symValid <= 1'h1;
		symIn <= t[2*i +: 2];
	end
	@(negedge clk);
	symValid <= 1'h0;
	symIn <= ~t[1:0];
endtask
endmodule // tpcsr_sym_src
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the ternary receive coding layer.
// Assumes tpcsr_receive, tpcsr_sym_src and tpcsr_rx_monitor are compiled.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
logic clk = 1'h0, rstn = 1'h0, mgmtReset = 1'h0, localReceiverHealth = 1'h1;
logic isMaster = 1'h0, loopbackEn = 1'h0, txEn = 1'h0, txEr = 1'h0;
logic [3:0] txd = 4'h0;
logic sawDv = 1'h0, sawEr = 1'h0, sawRecv = 1'h0, sawViol = 1'h0;
logic [31:0] rng = 32'h0001_403b;
logic [5:0] expv;
logic clrSaw = 1'h0, negTx = 1'h0;
wire symValid, rxDv, rxEr, receiving, descramblerLock, balanceViolation, overlongFrameFlag;
wire farReceiverHealth, farLowPowerRequest, rxPolarityFlipped, txMediumMute, codingLayerReset;
wire [1:0] symIn;
wire [3:0] rxd;
int n_mismatch = 0, n_checks = 0;

always #4 clk = ~clk;

tpcsr_receive uut (
	.clk(clk),
	.rstn(rstn),
	.mgmtReset(mgmtReset),
	.symValid(symValid),
	.symIn(symIn),
	.localReceiverHealth(localReceiverHealth),
	.isMaster(isMaster),
	.loopbackEn(loopbackEn),
	.txd(txd),
	.txEn(txEn),
	.txEr(txEr),
	.rxd(rxd),
	.rxDv(rxDv),
	.rxEr(rxEr),
	.receiving(receiving),
	.descramblerLock(descramblerLock),
	.balanceViolation(balanceViolation),
	.overlongFrameFlag(overlongFrameFlag),
	.farReceiverHealth(farReceiverHealth),
	.farLowPowerRequest(farLowPowerRequest),
	.rxPolarityFlipped(rxPolarityFlipped),
	.txMediumMute(txMediumMute),
	.codingLayerReset(codingLayerReset)
);
tpcsr_sym_src src (.clk(clk), .symValid(symValid), .symIn(symIn));

// Sticky event flags; one process owns them, the clear comes as a request
always @(posedge clk) begin
	if (clrSaw) begin
		{sawDv, sawEr, sawRecv, sawViol} <= 4'h0;
	end else begin
		sawDv <= sawDv | (rxDv === 1'h1);
		sawEr <= sawEr | (rxEr === 1'h1);
		sawRecv <= sawRecv | (receiving === 1'h1);
		sawViol <= sawViol | (balanceViolation === 1'h1);
	end
end

function logic [31:0] xs(input logic [31:0] x);
	x = x ^ (x << 13);
	x = x ^ (x >> 17);
	x = x ^ (x << 5);
	return x;
endfunction

// Swaps +1 and -1 in each symbol, zero stays
function automatic logic [5:0] neg6(input logic [5:0] t);
	logic [5:0] r;
	for (int i = 0; i < 3; i++)
		r[2*i +: 2] = 2'h0 - t[2*i +: 2];
	return r;
endfunction

task chk(input logic [7:0] seen, input logic [7:0] exp);
	n_checks++;
	if (seen !== exp) begin
		n_mismatch++;
		$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask

task tally_and_finish;
	$display("checks %0d mismatches %0d", n_checks, n_mismatch);
	if (n_mismatch == 0 && n_checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask

task clear_saw;
	clrSaw = 1'h1;
	@(negedge clk);
	clrSaw = 1'h0;
endtask

task do_reset;
	rstn = 1'h0;
	repeat (5) @(negedge clk);
	chk(codingLayerReset, 8'h01);
	chk(rxDv, 8'h00);
	chk(rxPolarityFlipped, 8'h00);
	rstn = 1'h1;
	repeat (3) @(negedge clk);
	clear_saw;
endtask

// Far end wired with swapped pair when negTx is set
task send(input logic [5:0] t);
	src.send_triple(negTx ? neg6(t) : t);
endtask

// Balance is 2 at both resets, so one reset code serves both ends
task frame(input logic [5:0] tail, input logic [5:0] first, input int nData);
	send(6'h30);
	send(6'h17);
	send(first);
	repeat (nData) send(6'h0d);
	send(6'h30);
	send(tail);
	repeat (8) send(6'h0d);
endtask

initial begin
	do_reset;
	src.send_triple(6'h0d);
	repeat (3) @(negedge clk);
	chk(sawViol, 0);
	src.send_triple(6'h15);
	repeat (3) @(negedge clk);
	chk(sawViol, 1);
	$display("test balance check done");
	// Frames: clean end, error end, no health, malformed end, bad data triple
	for (int k = 0; k < 5; k++) begin
		localReceiverHealth = (k != 2);
		isMaster = rng[3];
		do_reset;
		frame(k == 1 ? 6'h35 : (k == 3 ? 6'h0d : 6'h1d), k == 4 ? 6'h15 : 6'h0d,
			8 + rng[2:0]);
		rng = xs(rng);
		chk(sawDv, k != 2);
		chk(sawRecv, k != 2);
		chk(sawEr, k == 1 || k == 3 || k == 4);
		chk(rxDv, 0);
		$display("test frame %0d done", k);
	end
	// No lock within the window: polarity flips, a swapped pair then decodes
	localReceiverHealth = 1'h1;
	do_reset;
	repeat (65540) @(negedge clk);
	chk(rxPolarityFlipped, 8'h01);
	negTx = 1'h1;
	frame(6'h1d, 6'h0d, 8);
	negTx = 1'h0;
	chk(sawDv, 8'h01);
	chk(sawRecv, 8'h01);
	chk(rxPolarityFlipped, 8'h01);
	$display("test polarity done");
	mgmtReset = 1'h1;
	repeat (4) @(negedge clk);
	chk(codingLayerReset, 1);
	mgmtReset = 1'h0;
	$display("test management reset done");
	do_reset;
	loopbackEn = 1'h1;
	repeat (4) @(negedge clk);
	chk(txMediumMute, 1);
	for (int i = 0; i < 40; i++) begin
		{txd, txEn, txEr} = rng[5:0];
		expv = rng[5:0];
		rng = xs(rng);
		@(negedge clk);
		chk({rxd, rxDv, rxEr}, expv);
	end
	// Receiver isolated: a frame on the medium must not reach the MII
	{txd, txEn, txEr} = 6'h00;
	clear_saw;
	frame(6'h1d, 6'h0d, 8);
	chk(sawRecv, 8'h00);
	chk(rxDv, 8'h00);
	$display("test loopback done");
	tally_and_finish;
end
endmodule // tb_top

bind tpcsr_receive tpcsr_rx_monitor mon (
	.clk(clk),
	.rstn(rstn),
	.mgmtReset(mgmtReset),
	.symValid(symValid),
	.loopbackEn(loopbackEn),
	.txd(txd),
	.txEn(txEn),
	.txEr(txEr),
	.rxd(rxd),
	.rxDv(rxDv),
	.rxEr(rxEr),
	.receiving(receiving),
	.descramblerLock(descramblerLock),
	.balanceViolation(balanceViolation),
	.overlongFrameFlag(overlongFrameFlag),
	.rxPolarityFlipped(rxPolarityFlipped),
	.txMediumMute(txMediumMute),
	.codingLayerReset(codingLayerReset)
);
`default_nettype wire
